// ---- tb_top.sv ----
`timescale 1ns/10ps
`include "uptpc_regs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
  reg        i_mclk = 1'b0;
  reg        i_rst_n = 1'b0;
  reg        sup = 1'b1;
  reg        lock = 1'b0;
  reg  [1:0] ls = 2'b00;
  reg  [1:0] vb = 2'b00;
  reg        stb = 1'b0;
  reg  [6:0] wf = 7'h00;
  reg        wrst = 1'b0;
  wire [7:0] ldata, o_data, o_oe;
  wire       o_dir, o_nxt, pu, pdp, pdm, term, rbit, por, armed;
  integer    fail_count = 0, tests_run = 0, i, n, seed;
  reg  [7:0] last;
  reg  [6:0] s;
  reg        seen;
  wire [3:0] en = {pu, pdp, pdm, term};
  initial forever #4 i_mclk = ~i_mclk;
  uptpc_ctrl i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_supply_ok(sup), .i_pll_lock(lock),
    .i_line_state(ls), .i_vbus_state(vb), .i_wr_stb(stb), .i_wr_xcvr_sel(wf[6:5]),
    .i_wr_term_sel(wf[4]), .i_wr_opmode(wf[3:2]), .i_wr_ctrl_a(wf[1]), .i_wr_ctrl_b(wf[0]),
    .i_wr_reset(wrst), .i_rd_valid(1'b0), .i_rd_data(8'h00), .i_data(ldata), .o_dir(o_dir),
    .o_nxt(o_nxt), .o_data(o_data), .o_data_oe(o_oe), .o_dp_pullup_enable(pu),
    .o_ctrl_a_enable(pdp), .o_ctrl_b_enable(pdm), .o_hs_termination_enable(term),
    .o_reset_bit(rbit), .o_por(por));
  uptpc_link_model i_link (.i_mclk(i_mclk), .i_dir(o_dir), .i_reset_bit(rbit),
    .o_data(ldata), .o_armed(armed));
  // ==========================================================
  // Helpers
  function [3:0] exp_map(input [6:0] f);
    if (f[3:2] == `UPTPC_OPMODE_TRISTATE) exp_map = 4'h0;
    else exp_map = {f[4] & ~f[1], f[1], f[0], (f[6:5] == `UPTPC_XCVR_HS) & ~f[4]};
  endfunction
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task wr(input [6:0] f, input r);
    begin
      wf = f;
      wrst = r;
      stb = 1'b1;
      @(posedge i_mclk);
      #1 stb = 1'b0;
      wrst = 1'b0;
    end
  endtask
  // Steps until dir is low, keeping the last byte driven while high
  task wait_low;
    begin
      n = 0;
      while (o_dir !== 1'b0 && n < 600) begin
        last = o_data;
        @(posedge i_mclk);
        #1 n++;
      end
      if (n == 600) begin fail_count++; wrap_up; end
    end
  endtask
  task watch_por(input integer c);
    begin
      seen = 1'b0;
      repeat (c) begin @(posedge i_mclk); #1 seen = seen | (por === 1'b1); end
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    seed = $urandom(32'h739b);
    repeat (5) @(posedge i_mclk);
    #1 i_rst_n = 1'b1;
    repeat (40) @(posedge i_mclk);
    #1 `CHK(o_dir, 1'b1)
    lock = 1'b1;
    wait_low;
    `CHK(en, 4'b0110)
    for (i = 0; i < 40; i++) begin
      s = (i == 0) ? 7'h19 : (i == 1) ? 7'h07 : (i == 2) ? 7'h0b : $urandom;
      wr(s, 1'b0);
      repeat (2) @(posedge i_mclk);
      #1 `CHK(en, exp_map(s))
    end
    ls = $urandom;
    vb = $urandom;
    wr(7'h19, 1'b1);
    `CHK({o_dir, o_nxt, o_oe, rbit}, {2'b10, 8'hff, 1'b1})
    @(posedge i_mclk);
    #1 wr(7'h07, 1'b0);
    wait_low;
    `CHK(n > `UPTPC_SRST_CYCLES - 4, 1'b1)
    `CHK(last[3:0], {vb, ls})
    `CHK({rbit, en}, 5'b00110)
    `CHK(armed, 1'b1)
    sup = 1'b0;
    repeat (4) @(posedge i_mclk);
    #1 sup = 1'b1;
    watch_por(40);
    `CHK(seen, 1'b0)
    wr(7'h19, 1'b0);
    sup = 1'b0;
    repeat (20) @(posedge i_mclk);
    #1 sup = 1'b1;
    watch_por(60);
    `CHK(seen, 1'b1)
    wait_low;
    `CHK(en, 4'b0110)
    wrap_up;
  end
endmodule // tb_top

// ---- uptpc_ctrl.v ----
`timescale 1ns/10ps
`include "uptpc_regs.vh"

// Function
// - Resistor enables decoded purely from settings
// - Three-state opmode disables every resistor
// - DP pull-down follows its control bit
// - DM pull-down follows its control bit
// - HS termination when HS select, term 0
// - Pull-up when term 1, DP pull-down 0
// - Host FS states: only pull-downs on
// - Host chirp: pull-downs plus termination
// - OTG chirp: pull-up with DM pull-down
// - Long supply dip makes new POR pulse
// - DIR high until reset and PLL done
// - DIR drops after PLL lock at power-up; the end of a software reset does not check lock
// - DIR high: NXT low, RXCMD on data, or read data in the post-reset slot when valid
// - Software reset holds DIR high throughout
// - Reset end drops DIR, clears bit
// - One RXCMD slot after every software reset, read data when valid
// - RXCMD whenever DIR high, NXT low, except read data in the post-reset slot

module uptpc_ctrl #(
  parameter [15:0] SRST_CYCLES = `UPTPC_SRST_CYCLES,
  parameter [15:0] LOCK_FILT   = `UPTPC_LOCK_FILT
) (
  // Clock and reset
  input  wire       i_mclk,
  input  wire       i_rst_n,
  // Analog status pins
  input  wire       i_supply_ok,
  input  wire       i_pll_lock,
  input  wire [1:0] i_line_state,
  input  wire [1:0] i_vbus_state,
  // Register write port from the ULPI decoder
  input  wire       i_wr_stb,
  input  wire [1:0] i_wr_xcvr_sel,
  input  wire       i_wr_term_sel,
  input  wire [1:0] i_wr_opmode,
  input  wire       i_wr_ctrl_a,
  input  wire       i_wr_ctrl_b,
  input  wire       i_wr_reset,
  // Register read data return
  input  wire       i_rd_valid,
  input  wire [7:0] i_rd_data,
  // Link data bus in
  input  wire [7:0] i_data,
  // ULPI outputs
  output reg        o_dir,
  output reg        o_nxt,
  output reg  [7:0] o_data,
  output reg  [7:0] o_data_oe,
  // Resistor enables
  output reg        o_dp_pullup_enable,
  output reg        o_ctrl_a_enable,
  output reg        o_ctrl_b_enable,
  output reg        o_hs_termination_enable,
  // Status
  output reg        o_reset_bit,
  output reg        o_por
);

  localparam [2:0] ST_POR   = 3'd0;
  localparam [2:0] ST_LOCK  = 3'd1;
  localparam [2:0] ST_SRST  = 3'd2;
  localparam [2:0] ST_RXCMD = 3'd3;
  localparam [2:0] ST_IDLE  = 3'd4;

  // ========================================================
  // Bus ownership decode, shared by the DIR drive and the write gate
  function owns_bus;
    input [2:0] st;
    begin
      owns_bus = (st == ST_POR) || (st == ST_LOCK) ||
                 (st == ST_SRST) || (st == ST_RXCMD);
    end
  endfunction

  // ========================================================
  // Reset release and input synchronisers
  reg        rst_s1;
  reg        rst_s2;
  reg  [1:0] sup_s;
  reg  [1:0] lock_s;
  reg  [1:0] ls_s1;
  reg  [1:0] ls_s2;
  reg  [1:0] vb_s1;
  reg  [1:0] vb_s2;
  wire       rst_n = rst_s2;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      sup_s  <= 2'b00;
      lock_s <= 2'b00;
      ls_s1  <= 2'b00;
      ls_s2  <= 2'b00;
      vb_s1  <= 2'b00;
      vb_s2  <= 2'b00;
    end else begin
      sup_s  <= {sup_s[0], i_supply_ok};
      lock_s <= {lock_s[0], i_pll_lock};
      ls_s1  <= i_line_state;
      ls_s2  <= ls_s1;
      vb_s1  <= i_vbus_state;
      vb_s2  <= vb_s1;
    end
  end

  // ========================================================
  // Power-on pulse from the supply monitor
  wire por_pulse;

  uptpc_por_filter #(
    .LOW_MIN (`UPTPC_POR_LOW_MIN),
    .PULSE   (`UPTPC_POR_PULSE)
  ) u_por (
    .i_mclk      (i_mclk),
    .i_rst_n     (rst_n),
    .i_supply_ok (sup_s[1]),
    .o_por       (por_pulse)
  );

  // ========================================================
  // Control bits, reloaded to power-up values on POR
  reg  [1:0] xcvr_sel;
  reg        term_sel;
  reg  [1:0] opmode;
  reg        ctrl_a;
  reg        ctrl_b;
  reg  [2:0] state;
  reg  [2:0] next_state;
  reg [15:0] cnt;
  reg [15:0] next_cnt;

  // Restore and bit clear share the edge that leaves the reset count
  wire srst_done = (state == ST_SRST) && (cnt == 16'h0000);

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      xcvr_sel    <= `UPTPC_RST_XCVR;
      term_sel    <= `UPTPC_RST_TERM;
      opmode      <= `UPTPC_RST_OPMODE;
      ctrl_a      <= `UPTPC_RST_PD_A;
      ctrl_b      <= `UPTPC_RST_PD_B;
      o_reset_bit <= 1'b0;
    end else if (por_pulse || srst_done) begin
      // Whole-chip reset restores defaults; the reset bit self-clears
      xcvr_sel    <= `UPTPC_RST_XCVR;
      term_sel    <= `UPTPC_RST_TERM;
      opmode      <= `UPTPC_RST_OPMODE;
      ctrl_a      <= `UPTPC_RST_PD_A;
      ctrl_b      <= `UPTPC_RST_PD_B;
      o_reset_bit <= 1'b0;
    end else if (i_wr_stb && !owns_bus(state)) begin
      // A reset write loads the settings too; the restore overwrites them
      xcvr_sel    <= i_wr_xcvr_sel;
      term_sel    <= i_wr_term_sel;
      opmode      <= i_wr_opmode;
      ctrl_a      <= i_wr_ctrl_a;
      ctrl_b      <= i_wr_ctrl_b;
      o_reset_bit <= i_wr_reset;
    end
  end

  // ========================================================
  // Resistor decode, registered toward the analog pins
  wire dec_pu;
  wire dec_pd_dp;
  wire dec_pd_dm;
  wire dec_term;

  uptpc_resistor_map u_map (
    .i_xcvr_sel              (xcvr_sel),
    .i_term_sel              (term_sel),
    .i_opmode                (opmode),
    .i_ctrl_a                (ctrl_a),
    .i_ctrl_b                (ctrl_b),
    .o_dp_pullup_enable      (dec_pu),
    .o_ctrl_a_enable    (dec_pd_dp),
    .o_ctrl_b_enable    (dec_pd_dm),
    .o_hs_termination_enable (dec_term)
  );

  // Registered so the analog switches never see decode glitches
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_dp_pullup_enable      <= 1'b0;
      o_ctrl_a_enable    <= 1'b0;
      o_ctrl_b_enable    <= 1'b0;
      o_hs_termination_enable <= 1'b0;
    end else begin
      o_dp_pullup_enable      <= dec_pu;
      o_ctrl_a_enable    <= dec_pd_dp;
      o_ctrl_b_enable    <= dec_pd_dm;
      o_hs_termination_enable <= dec_term;
    end
  end

  // ========================================================
  // Power-up and software-reset sequencer
  always @* begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_POR: begin
        if (!por_pulse) begin
          next_state = ST_LOCK;
          next_cnt   = LOCK_FILT;
        end
      end
      ST_LOCK: begin
        // Lock must stay asserted a few cycles so a glitch cannot free the bus
        if (!lock_s[1])
          next_cnt = LOCK_FILT;
        else if (cnt != 16'h0000)
          next_cnt = cnt - 16'h0001;
        else
          next_state = ST_IDLE;
      end
      ST_SRST: begin
        if (cnt != 16'h0000)
          next_cnt = cnt - 16'h0001;
        else
          next_state = ST_RXCMD;
      end
      ST_RXCMD: begin
        next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (i_wr_stb && i_wr_reset) begin
          next_state = ST_SRST;
          next_cnt   = SRST_CYCLES;
        end
      end
      default: begin
        next_state = ST_POR;
      end
    endcase
    // A fresh power-on pulse overrides any state, a running reset included
    if (por_pulse)
      next_state = ST_POR;
  end

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_POR;
      cnt   <= 16'h0000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // ========================================================
  // ULPI pin drive
  // DIR follows the next state so it changes on the same edge as the state
  wire       dir_n = owns_bus(next_state);
  reg  [7:0] rxcmd;
  // Link bus is captured into data_in, which nothing reads; the command decoder sits outside this block
  reg  [7:0] data_in;

  // Only line and session status are reported; the upper bits stay low
  always @* begin
    rxcmd                           = `UPTPC_RXCMD_IDLE;
    rxcmd[`UPTPC_RXCMD_LS_LSB +: 2] = ls_s2;
    rxcmd[`UPTPC_RXCMD_VB_LSB +: 2] = vb_s2;
  end

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_dir     <= 1'b1;
      o_nxt     <= 1'b0;
      o_data    <= `UPTPC_RXCMD_IDLE;
      o_data_oe <= 8'h00;
      o_por     <= 1'b1;
      data_in   <= 8'h00;
    end else begin
      o_dir     <= dir_n;
      o_nxt     <= 1'b0;
      o_por     <= por_pulse;
      data_in   <= i_data;
      if (dir_n) begin
        o_data_oe <= 8'hff;
        o_data    <= (i_rd_valid && next_state == ST_RXCMD) ? i_rd_data : rxcmd;
      end else begin
        o_data_oe <= 8'h00;
        o_data    <= `UPTPC_RXCMD_IDLE;
      end
    end
  end

endmodule // uptpc_ctrl

// ---- uptpc_ctrl_properties.sv ----
`timescale 1ns/10ps
`include "uptpc_regs.vh"
// ==========================================================
// Port-level checks
module uptpc_ctrl_checker (
  input wire       i_mclk,
  input wire       i_rst_n,
  input wire       i_pll_lock,
  input wire       i_wr_stb,
  input wire [1:0] i_wr_opmode,
  input wire       i_wr_ctrl_a,
  input wire       i_wr_ctrl_b,
  input wire       i_wr_reset,
  input wire       o_dir,
  input wire       o_nxt,
  input wire [7:0] o_data_oe,
  input wire       o_dp_pullup_enable,
  input wire       o_ctrl_a_enable,
  input wire       o_ctrl_b_enable,
  input wire       o_hs_termination_enable,
  input wire       o_reset_bit,
  input wire       o_por
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  wire wr_ok = i_wr_stb && !o_dir && !i_wr_reset;
  wire tri_wr = wr_ok && (i_wr_opmode == `UPTPC_OPMODE_TRISTATE);
  wire any_on = o_dp_pullup_enable | o_ctrl_a_enable | o_ctrl_b_enable;
  a_nxt_dir_low: assert property (o_dir |-> !o_nxt) else $error("nxt high with dir");
  a_oe_when_idle: assert property (!o_dir |-> o_data_oe == 8'h00) else $error("oe idle");
  a_pullup_excl: assert property (o_dp_pullup_enable |-> !o_ctrl_a_enable &&
    !o_hs_termination_enable) else $error("pullup clash");
  a_tristate_off: assert property (tri_wr ##1 !i_wr_stb |=> !any_on &&
    !o_hs_termination_enable) else $error("tristate not off");
  a_dp_pd_follow: assert property (wr_ok && !tri_wr ##1 !i_wr_stb |=>
    o_ctrl_a_enable == $past(i_wr_ctrl_a, 2)) else $error("ctrl_a");
  a_dm_pd_follow: assert property (wr_ok && !tri_wr ##1 !i_wr_stb |=>
    o_ctrl_b_enable == $past(i_wr_ctrl_b, 2)) else $error("ctrl_b");
  a_srst_take: assert property (i_wr_stb && i_wr_reset && !o_dir |=>
    o_dir && o_reset_bit ##1 o_reset_bit[*8]) else $error("soft reset not held");
  a_bit_holds_dir: assert property (o_reset_bit |-> o_dir) else $error("dir low in reset");
  a_reset_end: assert property ($fell(o_reset_bit) |-> ##[0:2] !o_dir)
    else $error("dir stays high");
  a_por_holds_dir: assert property (o_por |-> o_dir) else $error("dir low in por");
  a_lock_first: assert property ($fell(o_dir) |-> $past(i_pll_lock, 4))
    else $error("dir fell unlocked");
  c_srst: cover property ($fell(o_reset_bit));
  c_tristate: cover property (tri_wr);
  c_pullup: cover property (o_dp_pullup_enable && o_ctrl_b_enable);
  c_por: cover property ($rose(o_por));
endmodule // uptpc_ctrl_checker
bind uptpc_ctrl uptpc_ctrl_checker i_chk (.*);

// ---- uptpc_link_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// Link side of the bus
module uptpc_link_model (
  input  wire       i_mclk,
  input  wire       i_dir,
  input  wire       i_reset_bit,
  output reg  [7:0] o_data,
  output reg        o_armed
);
  initial begin
    o_data = 8'h00;
    o_armed = 1'b0;
  end
  always @(posedge i_mclk) begin
    // Released bus toggles so a stale byte never looks valid
    o_data <= i_dir ? ~o_data : 8'h00;
    // Status bytes count only after the link has reset the device
    if (i_reset_bit) o_armed <= 1'b1;
  end
endmodule // uptpc_link_model

// ---- uptpc_por_filter.v ----
`timescale 1ns/10ps
`include "uptpc_regs.vh"

module uptpc_por_filter #(
  parameter [15:0] LOW_MIN = `UPTPC_POR_LOW_MIN,
  parameter [15:0] PULSE   = `UPTPC_POR_PULSE
) (
  // Clock and reset
  input  wire i_mclk,
  input  wire i_rst_n,
  // Synchronised supply-good level
  input  wire i_supply_ok,
  // Power-on pulse
  output reg  o_por
);

  reg [15:0] low_cnt;
  reg [15:0] pulse_cnt;
  reg        armed;

  // ========================================================
  // Dip filter: only dips longer than LOW_MIN re-arm the pulse
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt   <= 16'h0000;
      pulse_cnt <= PULSE;
      armed     <= 1'b0;
      o_por     <= 1'b1;
    end else begin
      if (!i_supply_ok) begin
        if (low_cnt < LOW_MIN)
          low_cnt <= low_cnt + 16'h0001;
        else
          armed <= 1'b1;
      end else begin
        low_cnt <= 16'h0000;
        if (armed) begin
          armed     <= 1'b0;
          pulse_cnt <= PULSE;
          o_por     <= 1'b1;
        end else if (pulse_cnt != 16'h0000) begin
          pulse_cnt <= pulse_cnt - 16'h0001;
          o_por     <= 1'b1;
        end else begin
          o_por     <= 1'b0;
        end
      end
    end
  end

endmodule // uptpc_por_filter

// ---- uptpc_regs.vh ----
`ifndef UPTPC_REGS_VH
`define UPTPC_REGS_VH

// ==========================================================
// Operating mode encodings
`define UPTPC_OPMODE_NORMAL     2'b00
`define UPTPC_OPMODE_TRISTATE   2'b01
`define UPTPC_OPMODE_NOSTUFF    2'b10
// ==========================================================
// Transceiver select encodings
`define UPTPC_XCVR_HS           2'b00
// ==========================================================
// Reset values of control bits (power-up state)
`define UPTPC_RST_XCVR          2'b01
`define UPTPC_RST_TERM          1'b0
`define UPTPC_RST_OPMODE        2'b00
`define UPTPC_RST_PD_A          1'b1
`define UPTPC_RST_PD_B          1'b1
// ==========================================================
// Receive-command field positions
`define UPTPC_RXCMD_LS_LSB      0
`define UPTPC_RXCMD_VB_LSB      2
`define UPTPC_RXCMD_IDLE        8'h00
// ==========================================================
// Timing counts in clock cycles
`define UPTPC_POR_LOW_MIN       16'd8
`define UPTPC_POR_PULSE         16'd16
`define UPTPC_SRST_CYCLES       16'd32
`define UPTPC_LOCK_FILT         16'd4

`endif

// ---- uptpc_resistor_map.v ----
`timescale 1ns/10ps
`include "uptpc_regs.vh"

module uptpc_resistor_map (
  // Control
  input  wire [1:0] i_xcvr_sel,
  input  wire       i_term_sel,
  input  wire [1:0] i_opmode,
  input  wire       i_ctrl_a,
  input  wire       i_ctrl_b,
  // Resistor enables
  output reg        o_dp_pullup_enable,
  output reg        o_ctrl_a_enable,
  output reg        o_ctrl_b_enable,
  output reg        o_hs_termination_enable
);

  // ========================================================
  // Pure decode of the settings
  always @* begin
    if (i_opmode == `UPTPC_OPMODE_TRISTATE) begin
      o_dp_pullup_enable      = 1'b0;
      o_ctrl_a_enable    = 1'b0;
      o_ctrl_b_enable    = 1'b0;
      o_hs_termination_enable = 1'b0;
    end else begin
      o_ctrl_a_enable    = i_ctrl_a;
      o_ctrl_b_enable    = i_ctrl_b;
      o_hs_termination_enable = (i_xcvr_sel == `UPTPC_XCVR_HS) && !i_term_sel;
      // Host pull-downs suppress the pull-up; OTG keeps it with only DM down
      o_dp_pullup_enable      = i_term_sel && !i_ctrl_a;
    end
  end

endmodule // uptpc_resistor_map
